/* File: logic/video_capture_crop_scale_size.sv */
/*
 * capture crop window and captured-size down-scaler with its processor-port registers.
 * assumes active-high syncs (inactive edge = falling), pixels synchronous to clk,
 * and a receiver that may stall through out_ready.
 */
// Notes on behaviour
// R1 - The vertical crop start is an 11-bit line count from the inactive vertical sync edge to the first kept line, held in bits 4 to 15.
// R2 - The vertical crop end is an 11-bit line count from the inactive vertical sync edge to the last kept line, held in bits 20 to 31.
// R3 - The captured height in lines is an 11-bit field in bits 4 to 15 of the size register.
// R4 - The captured width is an 11-bit field in bits 20 to 31 of the size register.
// R5 - When the captured size is below the cropped size, an accumulator drops lines and pixels to down-scale automatically.
// R6 - The horizontal crop start and end are 12-bit pixel counts from the inactive horizontal sync edge.
// R7 - Reserved bits 0 to 3 and 16 to 19 ignore writes and read back as zero.
`timescale 1ns/100ps
`default_nettype none
module video_capture_crop_scale_size
    import vcap_pkg::*;
(
    input  wire logic              clk,        // 40 MHz clock
    input  wire logic              resetn,     // async reset, low
    input  wire logic              reg_cs,     // register port select
    input  wire logic              reg_wr,     // 1 write, 0 read
    input  wire logic [ADDR_W-1:0] reg_addr,   // byte address
    input  wire logic [DATA_W-1:0] reg_wdata,  // write data
    output logic      [DATA_W-1:0] reg_rdata,  // read data, registered
    input  wire logic              vid_valid,  // pixel strobe
    input  wire vid_in_t           vid_in,     // pixel and syncs
    output logic                   vid_ready,  // buffer has room
    output logic                   out_valid,  // captured pixel held
    input  wire logic              out_ready,  // receiver takes
    output vid_out_t               out_pix     // captured pixel
);
    logic [DATA_W-1:0] hcrop_ff, vcrop_ff, size_ff, rdata_ff;
    logic [DATA_W-1:0] nxt_hcrop, nxt_vcrop, nxt_size, nxt_rdata;
    logic              hs_ff, vs_ff, nxt_hs, nxt_vs;
    logic [VCNT_W-1:0] vcnt_ff, nxt_vcnt;
    logic [HCNT_W-1:0] hcnt_ff, nxt_hcnt;
    logic [HCNT_W:0]   vacc_ff, nxt_vacc, hacc_ff, nxt_hacc;
    logic              line_keep_ff, nxt_line_keep;
    logic              sof_ff, nxt_sof, sol_ff, nxt_sol;
    logic              buf_valid;
    vid_out_t          buf_data;
    logic [HCNT_W-1:0] h_start, h_end, crop_w;
    logic [VCNT_W-1:0] v_start, v_end, cap_h, cap_w, crop_h;
    logic              hs_fall, vs_fall;
    logic [VCNT_W-1:0] line_idx;

    function automatic logic [HCNT_W-1:0] fld(input logic [DATA_W-1:0] w, input int lsb);
        fld = w[lsb +: HCNT_W];
    endfunction

    // one accumulator step: true when an output sample is due
    function automatic logic dda_emit(input logic [HCNT_W:0] acc, input logic [HCNT_W:0] step,
                                      input logic [HCNT_W:0] span);
        dda_emit = (acc + step) >= span;
    endfunction

    assign h_start = fld(hcrop_ff, HI_LSB);                              // R6
    assign h_end   = fld(hcrop_ff, LO_LSB);                              // R6
    assign v_start = VCNT_W'(fld(vcrop_ff, HI_LSB));                     // R1
    assign v_end   = VCNT_W'(fld(vcrop_ff, LO_LSB));                     // R2
    assign cap_h   = VCNT_W'(fld(size_ff, HI_LSB));                      // R3
    assign cap_w   = VCNT_W'(fld(size_ff, LO_LSB));                      // R4
    assign crop_w  = h_end - h_start + HCNT_W'(1);
    assign crop_h  = v_end - v_start + VCNT_W'(1);
    assign hs_fall = vid_valid && hs_ff && !vid_in.hsync;                // R6
    assign vs_fall = vid_valid && vs_ff && !vid_in.vsync;                // R1
    assign line_idx = vcnt_ff + VCNT_W'(1);

    // register port
    always_comb
    begin
        nxt_hcrop = hcrop_ff;
        nxt_vcrop = vcrop_ff;
        nxt_size  = size_ff;
        nxt_rdata = rdata_ff;
        if (reg_cs && reg_wr)
        begin
            unique case (reg_addr)
                ADDR_HCROP: nxt_hcrop = reg_wdata & MASK_12;             // R7
                ADDR_VCROP: nxt_vcrop = reg_wdata & MASK_11;             // R7
                ADDR_SIZE:  nxt_size  = reg_wdata & MASK_11;             // R7
                default:    ;
            endcase
        end
        else if (reg_cs)
        begin
            unique case (reg_addr)
                ADDR_HCROP: nxt_rdata = hcrop_ff;
                ADDR_VCROP: nxt_rdata = vcrop_ff;
                ADDR_SIZE:  nxt_rdata = size_ff;
                default:    nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hcrop_ff <= REG_RESET;
            vcrop_ff <= REG_RESET;
            size_ff  <= REG_RESET;
            rdata_ff <= '0;
        end
        else
        begin
            hcrop_ff <= nxt_hcrop;
            vcrop_ff <= nxt_vcrop;
            size_ff  <= nxt_size;
            rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata = rdata_ff;

    // timing counters, crop test and accumulators
    always_comb
    begin
        nxt_hs        = hs_ff;
        nxt_vs        = vs_ff;
        nxt_vcnt      = vcnt_ff;
        nxt_hcnt      = hcnt_ff;
        nxt_vacc      = vacc_ff;
        nxt_hacc      = hacc_ff;
        nxt_line_keep = line_keep_ff;
        nxt_sof       = sof_ff;
        nxt_sol       = sol_ff;
        buf_valid     = 1'b0;
        buf_data      = '{data: vid_in.data, sof: sof_ff, sol: sol_ff};
        if (vid_valid)
        begin
            nxt_hs = vid_in.hsync;
            nxt_vs = vid_in.vsync;
        end
        if (vs_fall)
        begin
            nxt_vcnt      = '0;                                          // R1
            nxt_vacc      = '0;
            nxt_line_keep = 1'b0;
            nxt_sof       = 1'b1;
        end
        else
        begin
            if (hs_fall)
            begin
                nxt_vcnt      = line_idx;                                // R2
                nxt_hcnt      = '0;                                      // R6
                nxt_hacc      = '0;
                nxt_sol       = 1'b1;
                nxt_line_keep = 1'b0;
                if (line_idx >= v_start && line_idx <= v_end)            // R1 R2
                begin
                    if (dda_emit(vacc_ff, (HCNT_W+1)'(cap_h), (HCNT_W+1)'(crop_h)))  // R5
                    begin
                        nxt_line_keep = 1'b1;
                        nxt_vacc = vacc_ff + (HCNT_W+1)'(cap_h) - (HCNT_W+1)'(crop_h);
                    end
                    else
                        nxt_vacc = vacc_ff + (HCNT_W+1)'(cap_h);
                end
            end
            // the sample on which hsync drops is already pixel 0 of its line
            if (vid_valid && !vid_in.hsync && !vid_in.vsync)
            begin
                if (nxt_line_keep && nxt_hcnt >= h_start && nxt_hcnt <= h_end)  // R6
                begin
                    if (dda_emit(nxt_hacc, (HCNT_W+1)'(cap_w), (HCNT_W+1)'(crop_w)))  // R5
                    begin
                        buf_valid = 1'b1;
                        buf_data  = '{data: vid_in.data, sof: nxt_sof, sol: nxt_sol};
                        nxt_hacc  = nxt_hacc + (HCNT_W+1)'(cap_w) - (HCNT_W+1)'(crop_w);
                        nxt_sof   = 1'b0;
                        nxt_sol   = 1'b0;
                    end
                    else
                        nxt_hacc = nxt_hacc + (HCNT_W+1)'(cap_w);
                end
                nxt_hcnt = nxt_hcnt + HCNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hs_ff        <= 1'b0;
            vs_ff        <= 1'b0;
            vcnt_ff      <= '0;
            hcnt_ff      <= '0;
            vacc_ff      <= '0;
            hacc_ff      <= '0;
            line_keep_ff <= 1'b0;
            sof_ff       <= 1'b0;
            sol_ff       <= 1'b0;
        end
        else
        begin
            hs_ff        <= nxt_hs;
            vs_ff        <= nxt_vs;
            vcnt_ff      <= nxt_vcnt;
            hcnt_ff      <= nxt_hcnt;
            vacc_ff      <= nxt_vacc;
            hacc_ff      <= nxt_hacc;
            line_keep_ff <= nxt_line_keep;
            sof_ff       <= nxt_sof;
            sol_ff       <= nxt_sol;
        end
    end

    // a captured pixel offered while vid_ready is low is dropped; the source should pause
    vcap_pair_buffer #(.WIDTH(OUT_W), .DEPTH(BUF_DEPTH)) u_buf (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (buf_valid),
        .in_ready  (vid_ready),
        .in_data   (buf_data),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_pix)
    );
endmodule // video_capture_crop_scale_size
`default_nettype wire

/* File: inc/vcap_pkg.sv */
/*
 * constants, field layouts and carrier types of the capture crop and size block.
 * assumes bit 0 of a printed field is the msb of the 32-bit word (bit n = word bit 31-n).
 */
`default_nettype none
package vcap_pkg;
    localparam int          ADDR_W        = 9;
    localparam int          DATA_W        = 32;
    localparam int          PIX_W         = 24;
    localparam int          HCNT_W        = 12;
    localparam int          VCNT_W        = 11;
    localparam int          BUF_DEPTH     = 2;
    localparam logic [8:0]  ADDR_HCROP    = 9'h1C4;
    localparam logic [8:0]  ADDR_VCROP    = 9'h1C8;
    localparam logic [8:0]  ADDR_SIZE     = 9'h1CC;
    // first-half field sits in word bits 27:16, second-half field in 11:0
    localparam int          HI_LSB        = 16;
    localparam int          LO_LSB        = 0;
    localparam logic [31:0] MASK_12       = 32'h0FFF_0FFF;
    localparam logic [31:0] MASK_11       = 32'h07FF_07FF;
    localparam logic [31:0] REG_RESET     = 32'h0000_0000;

    typedef struct packed {
        logic [PIX_W-1:0] data;
        logic             hsync;
        logic             vsync;
    } vid_in_t;

    typedef struct packed {
        logic [PIX_W-1:0] data;
        logic             sof;
        logic             sol;
    } vid_out_t;

    localparam int OUT_W = $bits(vid_out_t);
endpackage
`default_nettype wire

/* File: logic/vcap_pair_buffer.sv */
/*
 * two-entry valid/ready buffer for captured pixels.
 * assumes one clock, asynchronous active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none
module vcap_pair_buffer
    import vcap_pkg::*;
#(
    parameter int WIDTH = OUT_W,
    parameter int DEPTH = BUF_DEPTH
)
(
    input  wire logic             clk,     // clock
    input  wire logic             resetn,  // async reset, low
    input  wire logic             in_valid,// word offered
    output logic                  in_ready,// room for a word
    input  wire logic [WIDTH-1:0] in_data, // word in
    output logic                  out_valid,// word held
    input  wire logic             out_ready,// receiver takes
    output logic      [WIDTH-1:0] out_data // oldest word
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] nxt_mem [DEPTH];
    logic [PW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [PW:0]      cnt_ff, nxt_cnt;
    logic             push, pop;

    assign in_ready  = (cnt_ff != (PW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        nxt_mem = mem_ff;
        nxt_wr  = wr_ff;
        nxt_rd  = rd_ff;
        nxt_cnt = cnt_ff;
        if (push)
        begin
            nxt_mem[wr_ff] = in_data;
            nxt_wr         = (wr_ff == PW'(DEPTH-1)) ? '0 : wr_ff + PW'(1);
        end
        if (pop)
            nxt_rd = (rd_ff == PW'(DEPTH-1)) ? '0 : rd_ff + PW'(1);
        if (push && !pop)
            nxt_cnt = cnt_ff + (PW+1)'(1);
        else if (pop && !push)
            nxt_cnt = cnt_ff - (PW+1)'(1);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_ff[i] <= '0;
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            mem_ff <= nxt_mem;
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end
endmodule // vcap_pair_buffer
`default_nettype wire

/* File: tb/vcap_properties.sv */
/* checker of the capture block's register port and output buffer.
   assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/100ps
`default_nettype none
module vcap_properties
    import vcap_pkg::*;
(
    input wire logic              clk,       // clock
    input wire logic              resetn,    // reset, low
    input wire logic              reg_cs,    // select
    input wire logic              reg_wr,    // write
    input wire logic [ADDR_W-1:0] reg_addr,  // address
    input wire logic [DATA_W-1:0] reg_wdata, // write data
    input wire logic [DATA_W-1:0] reg_rdata, // read data
    input wire logic              vid_valid, // strobe
    input wire vid_in_t           vid_in,    // pixel in
    input wire logic              vid_ready, // room
    input wire logic              out_valid, // pixel held
    input wire logic              out_ready, // taken
    input wire vid_out_t          out_pix    // pixel out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic rd = reg_cs && !reg_wr;
    wire logic wr = reg_cs && reg_wr;
    wire logic pix_in = vid_valid && !vid_in.hsync && !vid_in.vsync;
    wire logic hit = reg_addr == ADDR_HCROP || reg_addr == ADDR_VCROP || reg_addr == ADDR_SIZE;
    property p_rd_hold; !rd |=> $stable(reg_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_unmapped; rd && !hit |=> reg_rdata == '0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_vcrop_rw; wr && reg_addr == ADDR_VCROP ##1 rd && reg_addr == ADDR_VCROP
        |=> reg_rdata == ($past(reg_wdata, 2) & MASK_11); endproperty
    a_vcrop_rw: assert property (p_vcrop_rw) else $error("crop window readback");
    property p_size_rw; wr && reg_addr == ADDR_SIZE ##1 rd && reg_addr == ADDR_SIZE
        |=> reg_rdata == ($past(reg_wdata, 2) & MASK_11); endproperty
    a_size_rw: assert property (p_size_rw) else $error("size readback");
    property p_hcrop_rw; wr && reg_addr == ADDR_HCROP ##1 rd && reg_addr == ADDR_HCROP
        |=> reg_rdata == ($past(reg_wdata, 2) & MASK_12); endproperty
    a_hcrop_rw: assert property (p_hcrop_rw) else $error("row crop readback");
    property p_out_hold; out_valid && !out_ready |=> out_valid && $stable(out_pix); endproperty
    a_out_hold: assert property (p_out_hold) else $error("stalled pixel changed");
    property p_empty_room; !out_valid |-> vid_ready; endproperty
    a_empty_room: assert property (p_empty_room) else $error("empty buffer refuses");
    property p_fill_cause; !out_valid ##1 out_valid |-> $past(pix_in); endproperty
    a_fill_cause: assert property (p_fill_cause) else $error("pixel from nowhere");
endmodule // vcap_properties
bind video_capture_crop_scale_size vcap_properties chk (.clk, .resetn, .reg_cs, .reg_wr,
    .reg_addr, .reg_wdata, .reg_rdata, .vid_valid, .vid_in, .vid_ready, .out_valid,
    .out_ready, .out_pix);
`default_nettype wire

/* File: tb/vcap_source.sv */
/* video source model: one frame of sync pulses and pixels per call of frame().
   assumes the capture block samples on rising edges of clk. */
`timescale 1ns/100ps
`default_nettype none
module vcap_source
    import vcap_pkg::*;
(
    input  wire logic clk,       // clock
    output logic      vid_valid, // strobe
    output vid_in_t   vid_in     // pixel and syncs
);
    initial
    begin
        vid_valid = 1'b0;
        vid_in = '0;
    end
    task automatic put(input logic [1:0] syn, input logic [PIX_W-1:0] d);
        @(negedge clk);
        vid_valid = 1'b1;
        vid_in = {d, syn};
    endtask
    // pixel word carries its line and index so the bench can tell them apart
    task automatic frame(input int lines, input int npix);
        put(2'b01, '0);
        for (int l = 1; l <= lines; l++)
        begin
            put(2'b10, '0);
            for (int p = 0; p < npix; p++)
                put(2'b00, {12'(l), 12'(p)});
        end
        @(negedge clk);
        vid_valid = 1'b0;
        // released lines show no stale word
        vid_in = ~vid_in;
    endtask
endmodule // vcap_source
`default_nettype wire

/* File: tb/tb.sv */
/* bench of the capture crop and size block: register rows, then framed video.
   assumes the source model drives the video side and the checker is bound. */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import vcap_pkg::*;
    typedef struct packed { logic [8:0] a; logic [31:0] w; logic [31:0] e; } row_t;
    localparam row_t ROWS [6] = '{'{ADDR_HCROP, 32'hFFFF_FFFF, 32'h0FFF_0FFF},
        '{ADDR_VCROP, 32'hFFFF_FFFF, 32'h07FF_07FF}, '{ADDR_SIZE, 32'hFFFF_FFFF, 32'h07FF_07FF},
        '{ADDR_VCROP, 32'h1234_5678, 32'h0234_0678}, '{ADDR_SIZE, 32'hA5A5_5A5A, 32'h05A5_025A},
        '{9'h1D0, 32'hFFFF_FFFF, 32'h0000_0000}};
    logic              clk = 1'b0;
    logic              resetn = 1'b0;
    logic              reg_cs = 1'b0;
    logic              reg_wr = 1'b0;
    logic              out_ready = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [DATA_W-1:0] reg_rdata;
    logic              vid_valid, vid_ready, out_valid;
    vid_in_t           vid_in;
    vid_out_t          out_pix;
    vid_out_t          got[$], exp_q[$];
    int                error_cnt = 0, samples_checked = 0, cyc = 0;
    always #12.5 clk = ~clk;
    vcap_source src (.clk, .vid_valid, .vid_in);
    video_capture_crop_scale_size dut (.clk, .resetn, .reg_cs, .reg_wr, .reg_addr, .reg_wdata,
        .reg_rdata, .vid_valid, .vid_in, .vid_ready, .out_valid, .out_ready, .out_pix);
    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (out_valid === 1'b1 && out_ready)
            got.push_back(out_pix);
        if (cyc == 2000)
        begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic acc(input logic w, input logic [8:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_cs = 1'b1;
        reg_wr = w;
        reg_addr = a;
        reg_wdata = d;
    endtask
    task automatic rd(input logic [8:0] a, input logic [31:0] e);
        acc(1'b0, a, '0);
        @(negedge clk);
        reg_cs = 1'b0;
        cmp(reg_rdata, e);
    endtask
    // accumulator step: adds the output size, emits once the crop span is reached
    function automatic logic keep(input int i, s, e, o, inout int a);
        if (i < s || i > e)
            return 1'b0;
        if (o >= e - s + 1)
            return 1'b1;
        a += o;
        if (a < e - s + 1)
            return 1'b0;
        a -= e - s + 1;
        return 1'b1;
    endfunction
    task automatic vtest(input int hs, he, vs, ve, h, w, lines, npix, input logic stall);
        int   va, ha;
        logic first, sl, vk;
        acc(1'b1, ADDR_HCROP, (hs << 16) | he);
        acc(1'b1, ADDR_VCROP, (vs << 16) | ve);
        acc(1'b1, ADDR_SIZE, (h << 16) | w);
        @(negedge clk);
        reg_cs = 1'b0;
        exp_q = {};
        got = {};
        first = 1'b1;
        va = 0;
        for (int l = 1; l <= lines; l++)
        begin
            vk = keep(l, vs, ve, h, va);
            ha = 0;
            sl = 1'b1;
            for (int p = 0; p < npix; p++)
                if (vk && keep(p, hs, he, w, ha))
                begin
                    exp_q.push_back({12'(l), 12'(p), first, sl});
                    first = 1'b0;
                    sl = 1'b0;
                end
        end
        out_ready = !stall;
        src.frame(lines, npix);
        // a stalled receiver keeps only what the buffer holds
        if (stall)
        begin
            while (exp_q.size() > BUF_DEPTH)
                exp_q.pop_back();
            cmp(32'(vid_ready), 32'h0000_0000);
        end
        out_ready = 1'b1;
        for (int i = 0; i < 20 && got.size() < exp_q.size(); i++)
            @(negedge clk);
        cmp(32'(got.size()), 32'(exp_q.size()));
        foreach (exp_q[i])
            if (i < got.size())
                cmp(32'(got[i]), 32'(exp_q[i]));
    endtask
    initial
    begin
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        rd(ADDR_HCROP, REG_RESET);
        rd(ADDR_VCROP, REG_RESET);
        rd(ADDR_SIZE, REG_RESET);
        foreach (ROWS[i])
        begin
            acc(1'b1, ROWS[i].a, ROWS[i].w);
            rd(ROWS[i].a, ROWS[i].e);
        end
        vtest(0, 3, 1, 1, 1, 2, 2, 4, 1'b1);
        vtest(1, 2, 2, 3, 1, 5, 4, 4, 1'b0);
        vtest(0, 7, 1, 1, 8, 8, 1, 8, 1'b1);
        // reset in mid-run empties a full buffer and clears the size and vertical crop registers
        out_ready = 1'b0;
        src.frame(1, 8);
        cmp(32'({out_valid, vid_ready}), 32'h0000_0002);
        resetn = 1'b0;
        @(negedge clk);
        cmp(32'({out_valid, vid_ready}), 32'h0000_0001);
        out_ready = 1'b1;
        resetn = 1'b1;
        rd(ADDR_SIZE, REG_RESET);
        rd(ADDR_VCROP, REG_RESET);
        wrap_up();
    end
endmodule // tb
`default_nettype wire
